// ---- src/cma_pkg.sv ----
package cma_pkg;
   localparam int PC_W          = 21;
   localparam int WORD_W        = 16;
   localparam int DADDR_W       = 12;
   localparam int BANK_W        = 4;
   localparam int OFS_W         = 8;
   localparam int DATA_W        = 8;
   localparam int NUM_BANKS     = 16;
   localparam int BANK_BYTES    = 256;
   localparam int ADDR_SPACE    = 4096;
   localparam logic [PC_W-1:0] PC_STEP      = 21'h000002;
   localparam logic [PC_W-1:0] PC_RESET     = 21'h000000;
   localparam logic [3:0]      NOP_PREFIX   = 4'hF;
   localparam int              LIT_W        = 12;
   localparam logic [OFS_W-1:0] ACCESS_SPLIT = 8'h60;
   localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
   localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hF;
   localparam logic [BANK_W-1:0] USB_DESC_BANK  = 4'h4;
   localparam logic [BANK_W-1:0] BANK_RESET     = 4'h0;
   localparam logic [DADDR_W-1:0] SPECIAL_BASE  = 12'hF40;
   localparam logic [DADDR_W-1:0] RAM_TOP_DEF   = 12'hEBF;
   localparam int BRANCH_CYCLES = 2;
   // first-word opcode prefixes of the four two-word operations, then the one-word relative-branch opcode
   localparam logic [6:0] OP_SUBR_JUMP  = 7'h76;
   localparam logic [7:0] OP_ABS_JUMP   = 8'hEF;
   localparam logic [3:0] OP_FILE_MOVE  = 4'hC;
   localparam logic [7:0] OP_PTR_LOAD   = 8'hEE;
   localparam logic [4:0] OP_REL_BRANCH = 5'h1A;
   typedef enum logic [2:0] {
      CMA_OP_NONE, CMA_OP_SUBR, CMA_OP_ABS, CMA_OP_MOVE, CMA_OP_PTR
   } cma_twoop_t;
endpackage : cma_pkg

// ---- src/cma_ram.sv ----
`timescale 1ns/1ns
module cma_ram
   import cma_pkg::*;
#(
   parameter int TOP_ADDR = 3775
)
(
   input  wire logic               clk,      // system clock
   input  wire logic               clkEn,    // freezes state when low
   input  wire logic               aWe,      // core write
   input  wire logic [DADDR_W-1:0] aAddr,    // core address
   input  wire logic [DATA_W-1:0]  aWdata,   // core write data
   output      logic [DATA_W-1:0]  aRdata,   // core read data
   input  wire logic               bWe,      // usb write
   input  wire logic [DADDR_W-1:0] bAddr,    // usb address
   input  wire logic [DATA_W-1:0]  bWdata,   // usb write data
   output      logic [DATA_W-1:0]  bRdata    // usb read data
);
   if (TOP_ADDR < 1 || TOP_ADDR >= ADDR_SPACE)
   begin : g_bad_top
      $error("cma_ram: TOP_ADDR out of range");
   end

   logic [DATA_W-1:0] mem [0:TOP_ADDR];

   // true dual port: neither side waits; same-cycle same-address write gives core priority
   always_ff @(posedge clk)
   begin
      if (clkEn)
      begin
         if (bWe && (int'(bAddr) <= TOP_ADDR) && !(aWe && aAddr == bAddr))
            mem[bAddr] <= bWdata;
         if (aWe && (int'(aAddr) <= TOP_ADDR))
            mem[aAddr] <= aWdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (clkEn)
      begin
         aRdata <= (int'(aAddr) <= TOP_ADDR) ? mem[aAddr] : '0;
         bRdata <= (int'(bAddr) <= TOP_ADDR) ? mem[bAddr] : '0;
      end
   end
endmodule : cma_ram

// ---- src/cma_core_addr.sv ----
`timescale 1ns/1ns
module cma_core_addr
   import cma_pkg::*;
#(
   parameter int RAM_TOP = 3775
)
(
   input  wire logic               clk,          // 50 MHz system clock
   input  wire logic               rst_n,        // async reset, active low
   input  wire logic               clkEn,        // freezes all state when low
   output      logic [PC_W-1:0]    progAddr,     // program memory byte address
   input  wire logic [WORD_W-1:0]  progWord,     // fetched instruction word
   input  wire logic               skipReq,      // skip next word (same clock)
   input  wire logic               bankLoad,     // load bank selector
   input  wire logic [BANK_W-1:0]  bankValue,    // new bank selector value
   output      logic [BANK_W-1:0]  bankSelector, // current bank selector
   input  wire logic               dataReq,      // core data access this cycle
   input  wire logic               dataWe,       // core write
   input  wire logic               accessSel,    // 0 forces fast-access bank
   input  wire logic [OFS_W-1:0]   dataOfs,      // offset from instruction
   input  wire logic               fullAddrSel,  // use full address
   input  wire logic [DADDR_W-1:0] fullAddr,     // full twelve-bit address
   input  wire logic [DATA_W-1:0]  dataWdata,    // core write data
   output      logic [DATA_W-1:0]  dataRdata,    // core read data
   output      logic [DADDR_W-1:0] dataAddr,     // resolved core address
   input  wire logic               usbEnable,    // usb module enabled
   input  wire logic               usbWe,        // usb engine write
   input  wire logic [DADDR_W-1:0] usbAddr,      // usb engine address
   input  wire logic [DATA_W-1:0]  usbWdata,     // usb engine write data
   output      logic [DATA_W-1:0]  usbRdata,     // usb engine read data
   output      logic               descRegion,   // core address in descriptor bank, usb enabled
   output      logic               twoWordBusy,  // second word pending
   output      cma_twoop_t         opKind,       // completed two-word op
   output      logic               opValid,      // pulse: two-word op completed
   output      logic [WORD_W-1:0]  opFirst,      // first word of completed op
   output      logic [LIT_W-1:0]   opLiteral,    // literal from second word
   output      logic               nopExec,      // pulse: word executed as nop
   output      logic               flushing      // pulse: prefetch being flushed
);
   // refuse a RAM top that would reach into the register-file area
   if (RAM_TOP < 1 || RAM_TOP >= int'(SPECIAL_BASE))
   begin : g_bad_top
      $error("cma_core_addr: RAM_TOP out of range");
   end

   logic [PC_W-1:0]   programCounter;
   logic [PC_W-1:0]   next_programCounter;
   logic              flushNext;
   logic              skipPending;
   logic              pendTwo;
   cma_twoop_t        pendKind;
   logic [WORD_W-1:0] pendWord;
   cma_twoop_t        firstKind;
   logic              isSecond;
   logic              branchTaken;
   logic [PC_W-1:0]   branchTarget;
   logic [10:0]       relOfs;
   logic [DADDR_W-1:0] resolvedAddr;
   logic [DADDR_W-1:0] coreAddr;
   logic              coreWe;
   logic              specialHit;
   logic [DATA_W-1:0] ramRdata;
   logic              specialHitQ;

   assign progAddr = programCounter;

   // decode first word of a two-word operation
   always_comb
   begin
      firstKind = CMA_OP_NONE;
      if (progWord[15:9] == OP_SUBR_JUMP)
         firstKind = CMA_OP_SUBR;
      else if (progWord[15:8] == OP_ABS_JUMP)
         firstKind = CMA_OP_ABS;
      else if (progWord[15:12] == OP_FILE_MOVE)
         firstKind = CMA_OP_MOVE;
      else if (progWord[15:8] == OP_PTR_LOAD && progWord[7:6] == 2'b00)
         firstKind = CMA_OP_PTR;
   end

   assign isSecond = (progWord[15:12] == NOP_PREFIX);
   assign relOfs   = progWord[10:0];

   // branch decision for the word in execute
   always_comb
   begin
      branchTaken  = 1'b0;
      branchTarget = programCounter;
      if (!flushNext && !skipPending)
      begin
         if (pendTwo && isSecond && (pendKind == CMA_OP_SUBR || pendKind == CMA_OP_ABS))
         begin
            branchTaken  = 1'b1;
            // word address into bits 20..1
            branchTarget = {progWord[11:0], pendWord[7:0], 1'b0};
         end
         else if (!pendTwo && progWord[15:11] == OP_REL_BRANCH)
         begin
            branchTaken = 1'b1;
            // offset in words, so shift left by one for bytes
            branchTarget = programCounter + {{9{relOfs[10]}}, relOfs, 1'b0};
         end
      end
   end

   always_comb
   begin
      if (branchTaken)
         next_programCounter = branchTarget;
      else if (flushNext)
         // flush cycle holds the target so that it executes next
         next_programCounter = programCounter;
      else
         next_programCounter = programCounter + PC_STEP;
      next_programCounter[0] = 1'b0;
   end

   // program counter; words are two bytes, a pair makes four
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         programCounter <= PC_RESET;
      else if (clkEn)
         programCounter <= next_programCounter;
   end

   // flush the prefetched word after a branch: costs one extra cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         flushNext <= 1'b0;
      else if (clkEn)
         flushNext <= branchTaken;
   end

   assign flushing = flushNext;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         skipPending <= 1'b0;
      else if (clkEn)
         skipPending <= skipReq && !flushNext;
   end

   // two-word tracking: a second word only counts straight after its first
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pendTwo  <= 1'b0;
         pendKind <= CMA_OP_NONE;
         pendWord <= '0;
      end
      else if (clkEn)
      begin
         if (flushNext || skipPending || pendTwo)
         begin
            pendTwo  <= 1'b0;
            pendKind <= CMA_OP_NONE;
         end
         else
         begin
            pendTwo  <= (firstKind != CMA_OP_NONE);
            pendKind <= firstKind;
            pendWord <= progWord;
         end
      end
   end

   assign twoWordBusy = pendTwo;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         opValid   <= 1'b0;
         opKind    <= CMA_OP_NONE;
         opFirst   <= '0;
         opLiteral <= '0;
         nopExec   <= 1'b0;
      end
      else if (clkEn)
      begin
         opValid <= 1'b0;
         nopExec <= 1'b0;
         if (!flushNext)
         begin
            if (pendTwo && isSecond && !skipPending)
            begin
               opValid   <= 1'b1;
               opKind    <= pendKind;
               opFirst   <= pendWord;
               opLiteral <= progWord[LIT_W-1:0];
            end
            else if (isSecond && !pendTwo)
               nopExec <= 1'b1;
         end
      end
   end

   // bank selector, upper four address bits
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         bankSelector <= BANK_RESET;
      else if (clkEn && bankLoad)
         bankSelector <= bankValue;
   end

   // data address resolution
   always_comb
   begin
      if (fullAddrSel)
         resolvedAddr = fullAddr;
      else if (!accessSel)
      begin
         // fast bank needs no selector, so one cycle
         if (dataOfs < ACCESS_SPLIT)
            resolvedAddr = {ACCESS_LO_BANK, dataOfs};
         else
            resolvedAddr = {ACCESS_HI_BANK, dataOfs};
      end
      else
         resolvedAddr = {bankSelector, dataOfs};
   end

   assign dataAddr   = resolvedAddr;
   assign coreAddr   = resolvedAddr;
   assign coreWe     = dataReq && dataWe && clkEn;
   assign specialHit = (resolvedAddr >= SPECIAL_BASE);
   // the descriptor bank stays plain RAM: usb use is by convention only
   assign descRegion = usbEnable && (resolvedAddr[DADDR_W-1:OFS_W] == USB_DESC_BANK);

   // register-file area lives elsewhere; here it and any gap read zero
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         specialHitQ <= 1'b0;
      else if (clkEn)
         specialHitQ <= specialHit;
   end

   assign dataRdata = specialHitQ ? '0 : ramRdata;

   // usb engine has its own port; size of descriptor use is its business
   cma_ram #(
      .TOP_ADDR (RAM_TOP)
   ) cma_ram_i (
      .clk    (clk),
      .clkEn  (clkEn),
      .aWe    (coreWe && !specialHit),
      .aAddr  (coreAddr),
      .aWdata (dataWdata),
      .aRdata (ramRdata),
      .bWe    (usbWe),
      .bAddr  (usbAddr),
      .bWdata (usbWdata),
      .bRdata (usbRdata)
   );
endmodule : cma_core_addr

// ---- tb/cma_prog_mem.sv ----
`timescale 1ns/1ns
module cma_prog_mem
   import cma_pkg::*;
(
   input  wire logic [PC_W-1:0]   progAddr, // byte address
   output      logic [WORD_W-1:0] progWord  // word at that address
);
   logic [WORD_W-1:0] mem [0:15];
   initial
   begin
      mem = '{16'h0000, 16'h0000, 16'hEF05, 16'hF000, 16'h0000, 16'hC123, 16'hF456, 16'h0000,
              16'hC123, 16'hF456, 16'hD002, 16'h0000, 16'hEE00, 16'hF789, 16'hD7FD, 16'h0000};
   end
   // bit 0 never selects a word; outside the image a changed pattern, not stale data
   assign progWord = (progAddr[PC_W-1:5] == '0) ? mem[progAddr[4:1]] : ~mem[progAddr[4:1]];
endmodule : cma_prog_mem

// ---- tb/cma_core_addr_assertions.sv ----
`timescale 1ns/1ns
module cma_core_addr_assertions
   import cma_pkg::*;
#(
   parameter int RAM_TOP = 3775
)
(
   input wire logic               clk,          // clock
   input wire logic               rst_n,        // reset
   input wire logic               clkEn,        // enable
   input wire logic [PC_W-1:0]    progAddr,     // pc
   input wire logic [WORD_W-1:0]  progWord,     // word
   input wire logic               skipReq,      // skip
   input wire logic [BANK_W-1:0]  bankSelector, // bank
   input wire logic               dataReq,      // access
   input wire logic               dataWe,       // write
   input wire logic               accessSel,    // banked
   input wire logic [OFS_W-1:0]   dataOfs,      // offset
   input wire logic               fullAddrSel,  // full select
   input wire logic [DADDR_W-1:0] fullAddr,     // full addr
   input wire logic [DATA_W-1:0]  dataRdata,    // read data
   input wire logic [DADDR_W-1:0] dataAddr,     // resolved
   input wire logic               twoWordBusy,  // pending
   input wire logic               opValid,      // op done
   input wire logic [LIT_W-1:0]   opLiteral,    // literal
   input wire logic               nopExec,      // nop
   input wire logic               flushing      // flush
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_align; progAddr[0] == 1'b0; endproperty
   a_align: assert property (p_align) else $error("pc odd");
   property p_step;
      rst_n && clkEn && !skipReq && !$past(skipReq) && !twoWordBusy && !flushing
      && progWord == 16'h0000
      |=> progAddr == $past(progAddr) + PC_STEP;
   endproperty
   a_step: assert property (p_step) else $error("pc step wrong");
   property p_jump;
      clkEn && twoWordBusy && progWord[15:12] == NOP_PREFIX && $past(progWord[15:8]) == OP_ABS_JUMP
      |=> progAddr == {$past(progWord[11:0]), $past(progWord[7:0], 2), 1'b0} && flushing;
   endproperty
   a_jump: assert property (p_jump) else $error("jump target wrong");
   property p_lit;
      clkEn && twoWordBusy && progWord[15:12] == NOP_PREFIX
      |=> opValid && opLiteral == $past(progWord[11:0]);
   endproperty
   a_lit: assert property (p_lit) else $error("literal not taken");
   property p_nop;
      clkEn && !twoWordBusy && !flushing && !$past(skipReq) && progWord[15:12] == NOP_PREFIX
      |=> nopExec && !opValid;
   endproperty
   a_nop: assert property (p_nop) else $error("lone second word not nop");
   property p_flush; flushing |=> !flushing; endproperty
   a_flush: assert property (p_flush) else $error("flush too long");
   property p_bank;
      dataReq && !fullAddrSel && accessSel |-> dataAddr == {bankSelector, dataOfs};
   endproperty
   a_bank: assert property (p_bank) else $error("banked address wrong");
   property p_fast;
      dataReq && !fullAddrSel && !accessSel
      |-> dataAddr == {(dataOfs < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK, dataOfs};
   endproperty
   a_fast: assert property (p_fast) else $error("fast bank map wrong");
   property p_full; dataReq && fullAddrSel |-> dataAddr == fullAddr; endproperty
   a_full: assert property (p_full) else $error("full address wrong");
   property p_zero;
      clkEn && dataReq && !dataWe && (dataAddr > RAM_TOP || dataAddr >= SPECIAL_BASE)
      |=> dataRdata == 8'h00;
   endproperty
   a_zero: assert property (p_zero) else $error("hole not zero");
endmodule : cma_core_addr_assertions

// ---- tb/tb_cma_core_addr.sv ----
`timescale 1ns/1ns
module tb_cma_core_addr
   import cma_pkg::*;
;
   localparam int RAM_TOP = 3775;
   logic clk, rst_n, clkEn, skipReq, bankLoad, dataReq, dataWe, accessSel, fullAddrSel;
   logic usbEnable, usbWe, descRegion, twoWordBusy, opValid, nopExec, flushing;
   logic [BANK_W-1:0]  bankValue, bankSelector;
   logic [OFS_W-1:0]   dataOfs;
   logic [DADDR_W-1:0] fullAddr, dataAddr, usbAddr;
   logic [DATA_W-1:0]  dataWdata, dataRdata, usbWdata, usbRdata;
   logic [PC_W-1:0]    progAddr;
   logic [WORD_W-1:0]  progWord, opFirst;
   logic [LIT_W-1:0]   opLiteral;
   cma_twoop_t         opKind;
   int                 errors, tests_run, cycles;
   cma_core_addr #(.RAM_TOP(RAM_TOP)) cma_core_addr_i (
      .clk          (clk),
      .rst_n        (rst_n),
      .clkEn        (clkEn),
      .progAddr     (progAddr),
      .progWord     (progWord),
      .skipReq      (skipReq),
      .bankLoad     (bankLoad),
      .bankValue    (bankValue),
      .bankSelector (bankSelector),
      .dataReq      (dataReq),
      .dataWe       (dataWe),
      .accessSel    (accessSel),
      .dataOfs      (dataOfs),
      .fullAddrSel  (fullAddrSel),
      .fullAddr     (fullAddr),
      .dataWdata    (dataWdata),
      .dataRdata    (dataRdata),
      .dataAddr     (dataAddr),
      .usbEnable    (usbEnable),
      .usbWe        (usbWe),
      .usbAddr      (usbAddr),
      .usbWdata     (usbWdata),
      .usbRdata     (usbRdata),
      .descRegion   (descRegion),
      .twoWordBusy  (twoWordBusy),
      .opKind       (opKind),
      .opValid      (opValid),
      .opFirst      (opFirst),
      .opLiteral    (opLiteral),
      .nopExec      (nopExec),
      .flushing     (flushing)
   );
   cma_prog_mem cma_prog_mem_i (.progAddr(progAddr), .progWord(progWord));
   always #10 clk = ~clk;
   task test_done;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   task check_val(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : check_val
   // bounded: a wrong branch shows as a mismatch instead of a hang
   task wait_pc(input logic [PC_W-1:0] a);
      int n;
      n = 0;
      @(negedge clk);
      while (progAddr !== a && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      check_val(progAddr, a);
   endtask : wait_pc
   task core_acc(input logic we, fs, as, input logic [7:0] ofs, input logic [11:0] fa,
                 input logic [7:0] wd, ex);
      @(posedge clk);
      {dataReq, dataWe, fullAddrSel, accessSel} <= {1'b1, we, fs, as};
      {dataOfs, fullAddr, dataWdata} <= {ofs, fa, wd};
      @(posedge clk);
      {dataReq, dataWe} <= 2'b00;
      @(negedge clk);
      if (!we)
         check_val(dataRdata, ex);
   endtask : core_acc
   task usb_acc(input logic we, input logic [11:0] a, input logic [7:0] wd, ex);
      @(posedge clk);
      {usbWe, usbAddr, usbWdata} <= {we, a, wd};
      @(posedge clk);
      usbWe <= 1'b0;
      @(negedge clk);
      if (!we)
         check_val(usbRdata, ex);
   endtask : usb_acc
   task t_jump;
      wait_pc(21'h000000);
      @(negedge clk);
      check_val(progAddr, 21'h000002);
      wait_pc(21'h000006);
      check_val(twoWordBusy, 1'b1);
      @(negedge clk);
      check_val(progAddr, 21'h00000A);
      check_val({opValid, flushing, opKind}, {2'b11, CMA_OP_ABS});
   endtask : t_jump
   task t_move_skip;
      wait_pc(21'h00000C);
      @(posedge clk);
      skipReq <= 1'b1;
      @(negedge clk);
      check_val({opValid, opKind}, {1'b1, CMA_OP_MOVE});
      check_val({opFirst, opLiteral}, {16'hC123, 12'h456});
      @(posedge clk);
      skipReq <= 1'b0;
      wait_pc(21'h000014);
      check_val({nopExec, opValid}, 2'b10);
      @(negedge clk);
      check_val({flushing, progAddr}, {1'b1, 21'h000018});
      wait_pc(21'h00001C);
      check_val({opValid, opKind, opLiteral}, {1'b1, CMA_OP_PTR, 12'h789});
      @(negedge clk);
      check_val(progAddr, 21'h000016);
   endtask : t_move_skip
   task t_data;
      @(posedge clk);
      {bankLoad, bankValue} <= {1'b1, 4'h3};
      @(posedge clk);
      bankLoad <= 1'b0;
      core_acc(1, 0, 1, 8'h55, 12'h000, 8'hA5, 8'h00);
      core_acc(0, 1, 0, 8'h00, 12'h355, 8'h00, 8'hA5);
      core_acc(1, 0, 0, 8'h10, 12'h000, 8'h3C, 8'h00);
      core_acc(0, 1, 0, 8'h00, 12'h010, 8'h00, 8'h3C);
      core_acc(1, 1, 0, 8'h00, 12'hEC0, 8'h77, 8'h00);
      core_acc(0, 1, 0, 8'h00, 12'hEC0, 8'h00, 8'h00);
      core_acc(0, 0, 0, 8'h70, 12'h000, 8'h00, 8'h00);
   endtask : t_data
   task t_usb;
      @(posedge clk);
      usbEnable <= 1'b1;
      usb_acc(1, 12'h410, 8'h5A, 8'h00);
      core_acc(0, 1, 0, 8'h00, 12'h410, 8'h00, 8'h5A);
      check_val(descRegion, 1'b1);
      @(posedge clk);
      usbEnable <= 1'b0;
      core_acc(1, 1, 0, 8'h00, 12'h420, 8'h99, 8'h00);
      check_val(descRegion, 1'b0);
      usb_acc(0, 12'h420, 8'h00, 8'h99);
   endtask : t_usb
   task t_collide;
      @(posedge clk);
      {dataReq, dataWe, fullAddrSel, fullAddr, dataWdata} <= {3'b111, 12'h100, 8'h11};
      {usbWe, usbAddr, usbWdata} <= {1'b1, 12'h100, 8'h22};
      @(posedge clk);
      {dataWe, usbWe} <= 2'b00;
      @(posedge clk);
      dataReq <= 1'b0;
      @(negedge clk);
      check_val({dataRdata, usbRdata}, 16'h1111);
   endtask : t_collide
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         test_done;
      end
   end
   initial
   begin
      {clk, rst_n, clkEn, skipReq, bankLoad, dataReq, dataWe, accessSel, fullAddrSel} = 9'h001;
      {clkEn, usbEnable, usbWe, bankValue, dataOfs, fullAddr, dataWdata} = '0;
      {usbAddr, usbWdata} = '0;
      clkEn = 1'b1;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_jump;
      t_move_skip;
      t_data;
      t_usb;
      t_collide;
      test_done;
   end
endmodule : tb_cma_core_addr
bind cma_core_addr cma_core_addr_assertions #(.RAM_TOP(RAM_TOP)) cma_core_addr_assertions_i (
   .clk          (clk),
   .rst_n        (rst_n),
   .clkEn        (clkEn),
   .progAddr     (progAddr),
   .progWord     (progWord),
   .skipReq      (skipReq),
   .bankSelector (bankSelector),
   .dataReq      (dataReq),
   .dataWe       (dataWe),
   .accessSel    (accessSel),
   .dataOfs      (dataOfs),
   .fullAddrSel  (fullAddrSel),
   .fullAddr     (fullAddr),
   .dataRdata    (dataRdata),
   .dataAddr     (dataAddr),
   .twoWordBusy  (twoWordBusy),
   .opValid      (opValid),
   .opLiteral    (opLiteral),
   .nopExec      (nopExec),
   .flushing     (flushing)
);
